// ### hw/blpw_cfg.svh
// Constants of the blink and PWM output controller.
// Assumes a 100 MHz clock; included by its bare name.
`ifndef BLPW_CFG_SVH
`define BLPW_CFG_SVH

// Register addresses
`define BLPW_ADDR_P0_LO    8'h02
`define BLPW_ADDR_P0_HI    8'h03
`define BLPW_ADDR_P1_LO    8'h0a
`define BLPW_ADDR_P1_HI    8'h0b
`define BLPW_ADDR_MG       8'h0e
`define BLPW_ADDR_CONFIG   8'h0f
`define BLPW_ADDR_INT_BASE 8'h10
`define BLPW_ADDR_INT_LAST 8'h17

// Reset values
`define BLPW_RST_OUT       8'hff
`define BLPW_RST_MG        8'h0f
`define BLPW_RST_CFG       8'h34
`define BLPW_RST_INT       8'hff

// Configuration register fields
`define BLPW_CFG_E         0
`define BLPW_CFG_B         1
`define BLPW_CFG_G         2
`define BLPW_CFG_O16_P0    4
`define BLPW_CFG_O16_P1    5
`define BLPW_CFG_BLINK     6

// Intensity field positions in the master and global register
`define BLPW_MG_MASTER_LSB 4
`define BLPW_MG_GLOBAL_LSB 0

// Timing
`define BLPW_CLK_HZ        100000000
`define BLPW_OSC_HZ        32000
`define BLPW_STEP_CYC      (`BLPW_CLK_HZ / `BLPW_OSC_HZ)
`define BLPW_SLOT_CYC      16
`define BLPW_SLOTS         15
`define BLPW_STATIC_INT    4'hf

`endif

// ### hw/blpw_pkg.sv
// Types shared by the blink and PWM output controller.
// Assumes nothing beyond a SystemVerilog compiler.
package blpw_pkg;

   // PWM time base as seen by every output channel
   typedef struct packed {
      logic       tick;
      logic       run;
      logic [3:0] cycle;
      logic [3:0] slot;
      logic [3:0] master;
   } blpw_tb_t;

   // Register write request
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } blpw_wr_t;

   typedef enum logic [1:0] {
      BLPW_STOP = 2'b01,
      BLPW_RUN  = 2'b10
   } blpw_tb_state_t;

endpackage

// ### hw/blpw_timebase.sv
// PWM oscillator and step counters of the output controller.
// Assumes a 100 MHz clock and a synchronous active-low reset.
`timescale 1ns/100ps
`include "blpw_cfg.svh"

module blpw_timebase (
   input  wire logic           clock,
   input  wire logic           nrst,
   input  wire logic [3:0]     master,
   output blpw_pkg::blpw_tb_t  tb
);

   blpw_pkg::blpw_tb_state_t state;
   blpw_pkg::blpw_tb_state_t next_state;
   logic [11:0]              div;
   logic [11:0]              next_div;
   blpw_pkg::blpw_tb_t       next_tb;

   always_comb begin
      next_state = state;
      next_div   = div;
      next_tb    = tb;
      next_tb.tick = 1'b0;
      unique case (state)
         blpw_pkg::BLPW_STOP: begin
            // Oscillator held still
            next_div       = 12'h000;
            next_tb.run    = 1'b0;
            next_tb.cycle  = 4'h0;
            next_tb.slot   = 4'h0;
            next_tb.master = master;
            if (master != 4'h0) begin
               next_state  = blpw_pkg::BLPW_RUN;
               next_tb.run = 1'b1;
            end
         end
         blpw_pkg::BLPW_RUN: begin
            if (master == 4'h0) begin
               next_state  = blpw_pkg::BLPW_STOP;
               next_tb.run = 1'b0;
            end else if (div == 12'(`BLPW_STEP_CYC - 1)) begin
               // One PWM step per oscillator period
               next_div       = 12'h000;
               next_tb.tick   = 1'b1;
               next_tb.master = master;
               // 16 cycles per slot, 15 slots per period
               if (tb.cycle == 4'(`BLPW_SLOT_CYC - 1)) begin
                  next_tb.cycle = 4'h0;
                  if (tb.slot == 4'(`BLPW_SLOTS - 1)) begin
                     next_tb.slot = 4'h0;
                  end else begin
                     next_tb.slot = tb.slot + 4'h1;
                  end
               end else begin
                  next_tb.cycle = tb.cycle + 4'h1;
               end
            end else begin
               next_div = div + 12'h001;
            end
         end
         default: begin
            next_state = blpw_pkg::BLPW_STOP;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         state <= blpw_pkg::BLPW_STOP;
         div   <= 12'h000;
         tb    <= '0;
      end else begin
         state <= next_state;
         div   <= next_div;
         tb    <= next_tb;
      end
   end

endmodule

// ### hw/blpw_chan.sv
// One open-drain output channel with PWM and static modes.
// Assumes the time base of blpw_timebase on the same clock.
`timescale 1ns/100ps
`include "blpw_cfg.svh"

module blpw_chan (
   input  wire logic           clock,
   input  wire logic           nrst,
   input  blpw_pkg::blpw_tb_t  tb,
   input  wire logic           lvl,
   input  wire logic [3:0]     inten,
   output logic                drive_low
);

   logic       sh_lvl;
   logic       next_sh_lvl;
   logic [3:0] sh_int;
   logic [3:0] next_sh_int;
   logic       next_drive_low;
   logic       pin_lvl;

   always_comb begin
      next_sh_lvl = sh_lvl;
      next_sh_int = sh_int;
      // New settings at a PWM cycle edge, or on every clock while stopped
      if (tb.tick || !tb.run) begin
         next_sh_lvl = lvl;
         next_sh_int = inten;
      end
      if (!tb.run || sh_int == `BLPW_STATIC_INT) begin
         // Static output, master ignored
         pin_lvl = sh_lvl;
      end else if (tb.slot < tb.master && tb.cycle <= sh_int) begin
         // Gated slot, n+1 cycles at level
         pin_lvl = sh_lvl;
      end else begin
         pin_lvl = ~sh_lvl;
      end
      // 1 floats, 0 pulls low
      next_drive_low = ~pin_lvl;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sh_lvl    <= 1'b1;
         sh_int    <= `BLPW_STATIC_INT;
         drive_low <= 1'b0;
      end else begin
         sh_lvl    <= next_sh_lvl;
         sh_int    <= next_sh_int;
         drive_low <= next_drive_low;
      end
   end

endmodule

// ### hw/blpw_top.sv
// Blink phase selection and PWM intensity for 17 open-drain outputs.
// Assumes a register port fed by a serial bus front end elsewhere.
//
// Function
// - Phase-0 output registers at 0x02 (outputs 7-0) and 0x03 (15-8).
// - Phase-1 output registers at 0x0A (outputs 7-0) and 0x0B (15-8).
// - PWM timed by a 32 kHz oscillator, stopped when PWM is off.
// - PWM period is 240 steps: 15 timeslots of 16 cycles.
// - Master intensity gates individual settings for 1 to 15 timeslots.
// - Individual setting acts only in gated slots, 1/16 to 15/16.
// - Setting 16/16 gives a static, glitch-free phase-register level.
// - Outputs 0-15 each have their own 4-bit intensity; global may replace them.
// - Blink off: phase-0 bits set levels during PWM on-time.
// - Bit 0 spans 1/16 to full on; bit 1 spans off to 15/16.
// - Blink on: phase-0 bits in phase 0, phase-1 bits in phase 1.
// - Seventeenth output intensity nibble doubles as global intensity.
// - Global mode: master and global nibbles form 240-step intensity.
// - Global intensity applies to outputs 0-15 all or none; the seventeenth always uses it.
// - Master register 0x00 to 0x0F makes every output static.
// - Global mode with nonzero master ignores registers 0x10 to 0x17.
// - Seventeenth output driven from configuration register bits, not a phase register.
// - Blink on: phase is software flip flag XOR blink input.
// - Register bit 1 floats the output, bit 0 pulls it low.
// - Seventeenth output level from one configuration bit per phase.
// - Zero master field stops the oscillator, outputs go static.
`timescale 1ns/100ps
`include "blpw_cfg.svh"

module blpw_top (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic [7:0]   reg_addr,
   input  wire logic         reg_wr,
   input  wire logic [7:0]   reg_wdata,
   output logic      [7:0]   reg_rdata,
   input  wire logic         blink_in,
   input  wire logic [16:0]  ld_in,
   output logic      [16:0]  ld_out,
   output logic      [16:0]  ld_oe
);

   blpw_pkg::blpw_wr_t wreq;
   blpw_pkg::blpw_tb_t tb;

   logic [15:0] phase0_outputs;
   logic [15:0] next_phase0_outputs;
   logic [15:0] phase1_outputs;
   logic [15:0] next_phase1_outputs;
   logic [7:0]  master_global;
   logic [7:0]  next_master_global;
   logic [7:0]  config_bits;
   logic [7:0]  next_config_bits;
   logic [7:0]  inten_reg      [8];
   logic [7:0]  next_inten_reg [8];
   logic [7:0]  next_reg_rdata;
   logic [16:0] next_ld_out;

   logic [3:0]  master;
   logic [3:0]  global_int;
   logic        global_on;
   logic        phase;
   logic [16:0] sel_lvl;

   assign wreq = '{wr: reg_wr, addr: reg_addr, data: reg_wdata};

   assign master     = master_global[`BLPW_MG_MASTER_LSB +: 4];
   assign global_int = master_global[`BLPW_MG_GLOBAL_LSB +: 4];

   // Register writes
   always_comb begin
      next_phase0_outputs = phase0_outputs;
      next_phase1_outputs = phase1_outputs;
      next_master_global  = master_global;
      next_config_bits    = config_bits;
      for (int k = 0; k < 8; k++) begin
         next_inten_reg[k] = inten_reg[k];
      end
      if (wreq.wr) begin
         unique case (wreq.addr)
            `BLPW_ADDR_P0_LO: next_phase0_outputs[7:0]  = wreq.data;
            `BLPW_ADDR_P0_HI: next_phase0_outputs[15:8] = wreq.data;
            `BLPW_ADDR_P1_LO: next_phase1_outputs[7:0]  = wreq.data;
            `BLPW_ADDR_P1_HI: next_phase1_outputs[15:8] = wreq.data;
            `BLPW_ADDR_MG:    next_master_global = wreq.data;
            // Blink status bit is read-only
            `BLPW_ADDR_CONFIG: begin
               next_config_bits = wreq.data & 8'h37;
            end
            default: begin
               if (wreq.addr >= `BLPW_ADDR_INT_BASE &&
                   wreq.addr <= `BLPW_ADDR_INT_LAST) begin
                  next_inten_reg[wreq.addr[2:0]] = wreq.data;
               end
            end
         endcase
      end
   end

   // Registered read port, unmapped addresses read zero
   always_comb begin
      next_reg_rdata = 8'h00;
      unique case (reg_addr)
         `BLPW_ADDR_P0_LO:  next_reg_rdata = phase0_outputs[7:0];
         `BLPW_ADDR_P0_HI:  next_reg_rdata = phase0_outputs[15:8];
         `BLPW_ADDR_P1_LO:  next_reg_rdata = phase1_outputs[7:0];
         `BLPW_ADDR_P1_HI:  next_reg_rdata = phase1_outputs[15:8];
         `BLPW_ADDR_MG:     next_reg_rdata = master_global;
         `BLPW_ADDR_CONFIG: begin
            next_reg_rdata = config_bits;
            next_reg_rdata[`BLPW_CFG_BLINK] = blink_in;
         end
         default: begin
            if (reg_addr >= `BLPW_ADDR_INT_BASE &&
                reg_addr <= `BLPW_ADDR_INT_LAST) begin
               next_reg_rdata = inten_reg[reg_addr[2:0]];
            end
         end
      endcase
   end

   // Phase choice
   always_comb begin
      if (config_bits[`BLPW_CFG_E]) begin
         phase = config_bits[`BLPW_CFG_B] ^ blink_in;
      end else begin
         phase = 1'b0;
      end
      // Global only with a running master
      global_on = config_bits[`BLPW_CFG_G] && (master != 4'h0);
      // Open-drain pins never drive high
      next_ld_out = 17'h00000;
   end

   blpw_timebase u_timebase (
      .clock  (clock),
      .nrst   (nrst),
      .master (master),
      .tb     (tb)
   );

   // One channel per output
   genvar i;
   generate
      for (i = 0; i < 17; i++) begin : g_chan
         logic [3:0] eff_int;
         if (i < 16) begin : g_main
            // Phase register bit per output
            assign sel_lvl[i] = phase ? phase1_outputs[i]
                                      : phase0_outputs[i];
            // Global for all or none
            assign eff_int = global_on ? global_int
                           : inten_reg[i / 2][(i % 2) * 4 +: 4];
         end else begin : g_o16
            // Own configuration bits
            assign sel_lvl[i] = phase ? config_bits[`BLPW_CFG_O16_P1]
                                      : config_bits[`BLPW_CFG_O16_P0];
            // Shared nibble
            assign eff_int = global_int;
         end
         blpw_chan u_chan (
            .clock     (clock),
            .nrst      (nrst),
            .tb        (tb),
            .lvl       (sel_lvl[i]),
            .inten     (eff_int),
            .drive_low (ld_oe[i])
         );
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!nrst) begin
         phase0_outputs <= {`BLPW_RST_OUT, `BLPW_RST_OUT};
         phase1_outputs <= {`BLPW_RST_OUT, `BLPW_RST_OUT};
         master_global  <= `BLPW_RST_MG;
         config_bits    <= `BLPW_RST_CFG;
         for (int k = 0; k < 8; k++) begin
            inten_reg[k] <= `BLPW_RST_INT;
         end
         reg_rdata      <= 8'h00;
         ld_out         <= 17'h00000;
      end else begin
         phase0_outputs <= next_phase0_outputs;
         phase1_outputs <= next_phase1_outputs;
         master_global  <= next_master_global;
         config_bits    <= next_config_bits;
         for (int k = 0; k < 8; k++) begin
            inten_reg[k] <= next_inten_reg[k];
         end
         reg_rdata      <= next_reg_rdata;
         ld_out         <= next_ld_out;
      end
   end

endmodule

// ### tb/blpw_properties.sv
// Port checker of the blink and PWM output controller.
// Assumes a bind to blpw_top from the testbench top file.
`timescale 1ns/100ps
module blpw_checker (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic [7:0]  reg_rdata,
   input  wire logic        blink_in,
   input  wire logic [16:0] ld_out,
   input  wire logic [16:0] ld_oe
);
   logic [7:0] cfg;
   logic [3:0] mst;

   // Shadow of configuration and master field
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cfg <= 8'h34;
         mst <= 4'h0;
      end else if (reg_wr) begin
         if (reg_addr == 8'h0f) cfg <= reg_wdata;
         if (reg_addr == 8'h0e) mst <= reg_wdata[7:4];
      end
   end

   // Seventeenth output level for a config value and blink input
   function automatic logic o16_lvl(input logic [7:0] c, input logic b);
      return (c[0] && (c[1] ^ b)) ? c[5] : c[4];
   endfunction

   sequence s_wr(a);
      reg_wr && reg_addr == a ##1 !reg_wr && reg_addr == a;
   endsequence

   property p_rst_clear;
      @(posedge clock) !nrst |=> ld_oe == 17'h0 && reg_rdata == 8'h00;
   endproperty
   property p_rst_float;
      @(posedge clock) disable iff (!nrst)
      $rose(nrst) |-> (ld_oe == 17'h0) [*4];
   endproperty
   property p_out_zero;
      @(posedge clock) disable iff (!nrst) ld_out == 17'h0;
   endproperty
   property p_p0_rd;
      @(posedge clock) disable iff (!nrst)
      s_wr(8'h02) or s_wr(8'h03) |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   property p_p1_rd;
      @(posedge clock) disable iff (!nrst)
      s_wr(8'h0a) or s_wr(8'h0b) |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   property p_cfg_rd;
      @(posedge clock) disable iff (!nrst) reg_addr == 8'h0f |=>
      !reg_rdata[7] && !reg_rdata[3] && reg_rdata[6] == $past(blink_in);
   endproperty
   property p_static;
      @(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == 8'h02 && mst == 4'h0 && !cfg[0] |->
      ##3 ld_oe[7:0] == ~$past(reg_wdata, 3);
   endproperty
   property p_o16_cfg;
      @(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == 8'h0f && mst == 4'h0 |->
      ##3 ld_oe[16] != o16_lvl($past(reg_wdata, 3), blink_in);
   endproperty
   property p_blink;
      @(posedge clock) disable iff (!nrst)
      $changed(blink_in) && mst == 4'h0 && cfg[0] |->
      ##3 ld_oe[16] != o16_lvl(cfg, blink_in);
   endproperty

   a_rst_clear: assert property (p_rst_clear) else $error("reset");
   a_rst_float: assert property (p_rst_float) else $error("float");
   a_out_zero: assert property (p_out_zero) else $error("ld_out");
   a_p0_rd: assert property (p_p0_rd) else $error("phase0 read");
   a_p1_rd: assert property (p_p1_rd) else $error("phase1 read");
   a_cfg_rd: assert property (p_cfg_rd) else $error("cfg read");
   a_static: assert property (p_static) else $error("static");
   a_o16_cfg: assert property (p_o16_cfg) else $error("o16");
   a_blink: assert property (p_blink) else $error("blink");
endmodule

// ### tb/blpw_load.sv
// Load model on the open-drain outputs.
// Assumes a pull-up resistor on every pin.
`timescale 1ns/100ps
module blpw_load (
   input  wire logic [16:0] ld_oe,
   output logic      [16:0] ld_in
);
   // Pin is low only while the device sinks it
   assign ld_in = ~ld_oe;
endmodule

// ### tb/testbench.sv
// Self-checking testbench of the blink and PWM output controller.
// Assumes blpw_top, blpw_load and blpw_checker are compiled before.
`timescale 1ns/100ps
module testbench;
   typedef struct {
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] cfg;
      logic       bl;
      logic [7:0] oe;
      logic       o16;
   } blpw_row_t;
   logic        clock = 1'b0;
   logic        nrst = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic        reg_wr = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        blink_in = 1'b0;
   logic [16:0] ld_in;
   logic [16:0] ld_out;
   logic [16:0] ld_oe;
   int          fails = 0;
   int          n_checks = 0;
   int          k;
   blpw_row_t   rows [7] = '{
      '{8'h5a, 8'ha5, 8'h34, 1'b0, 8'ha5, 1'b0},
      '{8'h5a, 8'ha5, 8'h35, 1'b0, 8'ha5, 1'b0},
      '{8'h5a, 8'ha5, 8'h35, 1'b1, 8'h5a, 1'b0},
      '{8'h0f, 8'hf0, 8'h07, 1'b1, 8'hf0, 1'b1},
      '{8'h0f, 8'hf0, 8'h07, 1'b0, 8'h0f, 1'b1},
      '{8'h00, 8'hff, 8'h02, 1'b1, 8'hff, 1'b1},
      '{8'h00, 8'hff, 8'h21, 1'b1, 8'h00, 1'b0}};
   logic [7:0]  rst_a [9] = '{8'h02, 8'h03, 8'h0a, 8'h0b, 8'h0e,
                             8'h0f, 8'h10, 8'h17, 8'h06};
   logic [7:0]  rst_v [9] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'h0f,
                             8'h34, 8'hff, 8'hff, 8'h00};

   blpw_top i_dut (
      .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .blink_in(blink_in),
      .ld_in(ld_in), .ld_out(ld_out), .ld_oe(ld_oe));
   blpw_load i_load (.ld_oe(ld_oe), .ld_in(ld_in));

   always #5 clock = ~clock;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(string what, logic [16:0] exp, logic [16:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask

   task automatic rd(logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      @(negedge clock);
      d = reg_rdata;
   endtask

   task automatic wait_oe(int b, logic v, int lim);
      k = 0;
      while (ld_oe[b] !== v && k < lim) begin
         @(negedge clock);
         k++;
      end
      if (k >= lim) begin
         fails++;
         $display("[ERR] wait ld_oe bit %0d expected %b", b, v);
         tally_and_finish();
      end
   endtask

   task automatic hold(logic [2:0] v, int n);
      int bad = 0;
      repeat (n) begin
         @(negedge clock);
         if (ld_oe[2:0] !== v) bad++;
      end
      check("held ld_oe cycles", 17'h0, bad[16:0]);
   endtask

   initial begin
      logic [7:0] d;
      repeat (8) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      foreach (rows[i]) begin
         blink_in = rows[i].bl;
         repeat (4) @(negedge clock);
         wr(8'h0f, rows[i].cfg);
         wr(8'h02, rows[i].p0);
         wr(8'h03, rows[i].p0);
         wr(8'h0a, rows[i].p1);
         wr(8'h0b, rows[i].p1);
         repeat (4) @(negedge clock);
         check("ld_oe", {rows[i].o16, {2{rows[i].oe}}}, ld_oe);
         rd(8'h0f, d);
         check("config", (rows[i].cfg & 8'h37) | {1'b0, rows[i].bl, 6'h00},
               d);
      end
      // Second reset in mid-run, then reset values
      nrst = 1'b0;
      blink_in = 1'b0;
      repeat (8) @(negedge clock);
      check("ld_oe in reset", 17'h0, ld_oe);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      foreach (rst_a[i]) begin
         rd(rst_a[i], d);
         check("reset value", rst_v[i], d);
      end
      // Individual PWM: output 0 at 1/16, output 1 at 2/16, output 2 static
      wr(8'h0f, 8'h30);
      wr(8'h02, 8'hf8);
      wr(8'h10, 8'h10);
      wr(8'h0e, 8'h10);
      wait_oe(0, 1'b0, 7000);
      wait_oe(1, 1'b0, 3200);
      check("step length", 17'd3125, k[16:0]);
      hold(3'b100, 8000);
      wr(8'h0e, 8'h00);
      repeat (3) @(negedge clock);
      check("stopped ld_oe", 17'h7, {14'h0, ld_oe[2:0]});
      wr(8'h0f, 8'h34);
      wr(8'h0e, 8'h1f);
      hold(3'b111, 8000);
      // Global nibble 0: static output 2 and the 17th start PWM
      wr(8'h0e, 8'h10);
      wait_oe(2, 1'b0, 7000);
      wait_oe(16, 1'b1, 7000);
      tally_and_finish();
   end
endmodule

bind blpw_top blpw_checker i_chk (
   .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .blink_in(blink_in),
   .ld_out(ld_out), .ld_oe(ld_oe));
